// ==== hbc_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module hbc_top
  import hbc_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = FIXED_OFF_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Variant straps
  input  wire logic              serial_variant_i,
  input  wire logic              ext_logic_supply_i,
  input  wire logic              logic_supply_ok_i,
  input  wire logic              motor_supply_ok_i,
  // Control pins
  input  wire logic              sleep_n_pin_i,
  input  wire logic              sleep_n_pin_driven_i,
  input  wire logic              drive_off_i,
  input  wire logic              drive_off_driven_i,
  input  wire logic              bridge_drive_cmd_i,
  input  wire logic              bridge_drive_cmd_driven_i,
  input  wire logic [SLEW_W-1:0] slew_setting_i,
  // Register copies
  input  wire logic              reg_drive_off_i,
  input  wire logic              reg_bridge_cmd_i,
  input  wire logic              drive_off_combine_sel_i,
  input  wire logic              bridge_cmd_combine_sel_i,
  input  wire logic              override_key_wr_i,
  input  wire logic [KEY_W-1:0]  override_lock_key_i,
  input  wire logic [SLEW_W-1:0] reg_slew_setting_i,
  input  wire logic              spread_spectrum_en_i,
  // Current regulation
  input  wire logic              trip_reg_en_i,
  input  wire logic              trip_cmp_i,
  // Gate feedback: switch fully off / fully on
  input  wire logic              hs_gate_off_i,
  input  wire logic              ls_gate_off_i,
  input  wire logic              hs_fully_on_i,
  // Outputs
  output logic                   hs_gate_en_o,
  output logic                   ls_gate_en_o,
  output logic                   half_bridge_output_oe_o,
  output logic                   half_bridge_output_o,
  output logic                   current_mirror_en_o,
  output logic                   offstate_diag_en_o,
  output logic [1:0]             state_o,
  output logic                   override_unlocked_o,
  output logic                   forced_low_o,
  output logic [SLEW_W-1:0]      slew_level_o,
  output logic signed [SSC_STEP_W-1:0] osc_trim_o
);

  // Pin path: pull defaults applied when undriven, then synchronised
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic [SLEW_W-1:0] slew_pin_sync;
  always_comb begin
    pin_raw[0] = sleep_n_pin_driven_i ? sleep_n_pin_i : 1'b0;
    pin_raw[1] = drive_off_driven_i ? drive_off_i : 1'b1;
    pin_raw[2] = bridge_drive_cmd_driven_i ? bridge_drive_cmd_i : 1'b0;
  end

  hbc_sync2 #(.W(3)) u_pin_sync (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .d_i       (pin_raw),
    .rst_val_i (3'b010),
    .q_o       (pin_sync)
  );

  hbc_sync2 #(.W(SLEW_W)) u_slew_sync (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .d_i       (slew_setting_i),
    .rst_val_i (SLEW_RST),
    .q_o       (slew_pin_sync)
  );

  // Sleep source: external logic supply variant has no sleep pin
  logic awake;
  assign awake = ext_logic_supply_i ? logic_supply_ok_i : pin_sync[0];

  // Override lock sequencer
  hbc_lock_e lock_r;
  hbc_lock_e lock_nxt;
  always_comb begin
    lock_nxt = lock_r;
    if (!awake || !serial_variant_i) begin
      lock_nxt = HBC_LK_LOCKED;
    end else if (override_key_wr_i) begin
      case (lock_r)
        HBC_LK_LOCKED: begin
          lock_nxt = (override_lock_key_i == KEY_UNLOCK_A) ? HBC_LK_HALF : HBC_LK_LOCKED;
        end
        HBC_LK_HALF: begin
          lock_nxt = (override_lock_key_i == KEY_UNLOCK_B) ? HBC_LK_OPEN : HBC_LK_LOCKED;
        end
        HBC_LK_OPEN: begin
          lock_nxt = (override_lock_key_i == KEY_LOCK) ? HBC_LK_LOCKED : HBC_LK_OPEN;
        end
        default: begin
          lock_nxt = HBC_LK_LOCKED;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lock_r <= HBC_LK_LOCKED;
    end else begin
      lock_r <= lock_nxt;
    end
  end
  logic unlocked;
  assign unlocked = (lock_r == HBC_LK_OPEN);

  // Effective inputs: register copies merged only when unlocked
  logic eff_off;
  logic eff_cmd;
  always_comb begin
    eff_off = pin_sync[1];
    eff_cmd = pin_sync[2];
    if (unlocked) begin
      eff_off = drive_off_combine_sel_i ? (pin_sync[1] & reg_drive_off_i)
                                        : (pin_sync[1] | reg_drive_off_i);
      eff_cmd = bridge_cmd_combine_sel_i ? (pin_sync[2] & reg_bridge_cmd_i)
                                         : (pin_sync[2] | reg_bridge_cmd_i);
    end
  end

  // State decode; motor supply absence just keeps bridge off safely
  hbc_state_e state;
  always_comb begin
    if (!awake) begin
      state = HBC_SLEEP;
    end else if (eff_off || !motor_supply_ok_i) begin
      state = HBC_STANDBY;
    end else begin
      state = HBC_ACTIVE;
    end
  end

  // Trip forced-low timer; input change cancels it
  logic [OFF_CNT_W-1:0] off_cnt_r;
  logic [OFF_CNT_W-1:0] off_cnt_nxt;
  logic                 prev_off_r;
  logic                 prev_cmd_r;
  logic                 in_change;
  assign in_change = (eff_off != prev_off_r) || (eff_cmd != prev_cmd_r);
  always_comb begin
    off_cnt_nxt = off_cnt_r;
    if (in_change || state != HBC_ACTIVE) begin
      off_cnt_nxt = '0;
    end else if (off_cnt_r != '0) begin
      off_cnt_nxt = off_cnt_r - 16'h0001;
    end else if (eff_cmd && trip_reg_en_i && trip_cmp_i && hs_gate_en_o) begin
      off_cnt_nxt = OFF_CNT_W'(OFF_CYCLES);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      off_cnt_r  <= '0;
      prev_off_r <= 1'b1;
      prev_cmd_r <= 1'b0;
    end else begin
      off_cnt_r  <= off_cnt_nxt;
      prev_off_r <= eff_off;
      prev_cmd_r <= eff_cmd;
    end
  end
  logic forced;
  assign forced = (off_cnt_r != '0);

  // Wanted switch and break-before-make gate control
  logic want_hs;
  logic want_ls;
  logic hs_r;
  logic hs_nxt;
  logic ls_r;
  logic ls_nxt;
  always_comb begin
    want_hs = (state == HBC_ACTIVE) && eff_cmd && !forced;
    want_ls = (state == HBC_ACTIVE) && (!eff_cmd || forced);
    // Turn on only once the other gate reports fully off
    hs_nxt = want_hs && !ls_r && ls_gate_off_i;
    ls_nxt = want_ls && !hs_r && hs_gate_off_i;
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
    end
  end

  // Slew: pin sampled at init, register live on serial variant
  logic [2:0]        init_cnt_r;
  logic [2:0]        init_cnt_nxt;
  logic [SLEW_W-1:0] slew_r;
  logic [SLEW_W-1:0] slew_nxt;
  always_comb begin
    init_cnt_nxt = init_cnt_r;
    slew_nxt     = slew_r;
    if (!awake) begin
      init_cnt_nxt = '0; // wake re-runs init
    end else if (init_cnt_r != 3'(INIT_CYCLES)) begin
      init_cnt_nxt = init_cnt_r + 3'h1;
    end
    if (serial_variant_i) begin
      slew_nxt = reg_slew_setting_i;
    end else if (awake && init_cnt_r == 3'(INIT_CYCLES - 1)) begin
      // Six pin levels; out of range codes clamp
      slew_nxt = (slew_pin_sync > SLEW_PIN_MAX) ? SLEW_PIN_MAX : slew_pin_sync;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      init_cnt_r <= '0;
      slew_r     <= SLEW_RST;
    end else begin
      init_cnt_r <= init_cnt_nxt;
      slew_r     <= slew_nxt;
    end
  end

  hbc_ssc u_ssc (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .enable_i (serial_variant_i && spread_spectrum_en_i),
    .trim_o   (osc_trim_o)
  );

  // Outputs
  assign hs_gate_en_o            = hs_r;
  assign ls_gate_en_o            = ls_r;
  assign half_bridge_output_oe_o = hs_r || ls_r;
  assign half_bridge_output_o    = hs_r;
  assign current_mirror_en_o     = hs_r && hs_fully_on_i && (state == HBC_ACTIVE);
  assign offstate_diag_en_o      = (state == HBC_STANDBY) && eff_cmd;
  assign state_o                 = state;
  assign override_unlocked_o     = unlocked;
  assign forced_low_o            = forced;
  assign slew_level_o            = slew_r;

  // Checks
  AST_NO_SHOOT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(hs_gate_en_o && ls_gate_en_o)) else $error("both switches on");
  AST_SLEEP_HIZ: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !awake |=> !awake |-> !half_bridge_output_oe_o) else $error("driven in sleep");
  AST_MIRROR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    current_mirror_en_o |-> (state == HBC_ACTIVE) && hs_gate_en_o) else $error("bad sense");
  AST_TRIP_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (off_cnt_r == '0 && off_cnt_nxt != '0) |=> off_cnt_r == OFF_CNT_W'(OFF_CYCLES))
    else $error("trip interval wrong");
  AST_TRIP_CANCEL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    in_change |=> !forced_low_o) else $error("change did not end trip");
  AST_LOCKED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !unlocked |-> eff_off == pin_sync[1] && eff_cmd == pin_sync[2])
    else $error("register copy used while locked");
  AST_OR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    unlocked && !drive_off_combine_sel_i && reg_drive_off_i |-> state != HBC_ACTIVE)
    else $error("or combine failed");
  AST_AND: assert property (@(posedge clk_i) disable iff (!rstn_i)
    unlocked && bridge_cmd_combine_sel_i && !reg_bridge_cmd_i |=> !hs_gate_en_o)
    else $error("and combine failed");
  AST_ACTIVE_HIGH: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hs_gate_en_o |-> $past(eff_cmd) && $past(state == HBC_ACTIVE))
    else $error("high without command");
  AST_SLEW_SERIAL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    serial_variant_i |=> slew_level_o == $past(reg_slew_setting_i))
    else $error("slew not immediate");

endmodule

`default_nettype wire

// ==== hbc_pkg.sv ====
package hbc_pkg;

  // Timing
  localparam int unsigned CLK_FREQ_HZ        = 20_000_000;
  localparam int unsigned FIXED_OFF_TIME_US  = 30;
  localparam int unsigned FIXED_OFF_CYCLES   = (FIXED_OFF_TIME_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned DEAD_FILTER_CYCLES = 2;
  localparam int unsigned INIT_CYCLES        = 4;

  // Widths
  localparam int unsigned SLEW_W    = 3;
  localparam int unsigned KEY_W     = 3;
  localparam int unsigned OFF_CNT_W = 16;

  // Slew level limits: pin variant tops out at six levels
  localparam logic [SLEW_W-1:0] SLEW_PIN_MAX = 3'h5;
  localparam logic [SLEW_W-1:0] SLEW_RST     = 3'h0;

  // Override lock: two step key sequence
  localparam logic [KEY_W-1:0] KEY_UNLOCK_A = 3'h3;
  localparam logic [KEY_W-1:0] KEY_UNLOCK_B = 3'h6;
  localparam logic [KEY_W-1:0] KEY_LOCK     = 3'h5;

  // Combine select reset: OR mode
  localparam logic COMBINE_SEL_RST = 1'b0;

  // Spread spectrum: +/-12 percent, triangle near 417 kHz
  localparam int unsigned SSC_SPREAD_PCT = 12;
  localparam int unsigned SSC_STEP_W     = 5;
  localparam logic [SSC_STEP_W-1:0] SSC_PEAK = 5'h0c;

  typedef enum logic [1:0] {
    HBC_SLEEP,
    HBC_STANDBY,
    HBC_ACTIVE
  } hbc_state_e;

  typedef enum logic [1:0] {
    HBC_LK_LOCKED,
    HBC_LK_HALF,
    HBC_LK_OPEN
  } hbc_lock_e;

endpackage

// ==== hbc_sync2.sv ====
`timescale 1ns/1ns
`default_nettype none

module hbc_sync2
  import hbc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Data
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Flops reset to zero; the pull value is supplied on the output instead
  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  // Reset value applied on output so flops hold constants only
  logic seen_r;
  logic seen_nxt;
  always_comb begin
    seen_nxt = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
    end
  end
  logic seen2_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      seen2_r <= 1'b0;
    end else begin
      seen2_r <= seen_r;
    end
  end

  assign q_o = seen2_r ? q_r : rst_val_i;

endmodule

`default_nettype wire

// ==== hbc_ssc.sv ====
`timescale 1ns/1ns
`default_nettype none

module hbc_ssc
  import hbc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Control
  input  wire logic                  enable_i,
  // Signed trim step, percent of mean frequency
  output logic signed [SSC_STEP_W-1:0] trim_o
);

  logic signed [SSC_STEP_W-1:0] trim_r;
  logic signed [SSC_STEP_W-1:0] trim_nxt;
  logic                         up_r;
  logic                         up_nxt;

  // Triangle sweep between -peak and +peak; one step per clock
  always_comb begin
    trim_nxt = trim_r;
    up_nxt   = up_r;
    if (!enable_i) begin
      trim_nxt = '0;
      up_nxt   = 1'b1;
    end else if (up_r) begin
      if (trim_r >= $signed(SSC_PEAK)) begin
        up_nxt   = 1'b0;
        trim_nxt = trim_r - 5'sh01;
      end else begin
        trim_nxt = trim_r + 5'sh01;
      end
    end else begin
      if (trim_r <= -$signed(SSC_PEAK)) begin
        up_nxt   = 1'b1;
        trim_nxt = trim_r + 5'sh01;
      end else begin
        trim_nxt = trim_r - 5'sh01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      trim_r <= '0;
      up_r   <= 1'b1;
    end else begin
      trim_r <= trim_nxt;
      up_r   <= up_nxt;
    end
  end

  assign trim_o = trim_r;

endmodule

`default_nettype wire

// ==== hbc_stage_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module hbc_stage_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Gate enables and pace
  input  wire logic hs_gate_en_i,
  input  wire logic ls_gate_en_i,
  input  wire logic slow_i,
  // Gate feedback
  output logic      hs_gate_off_o,
  output logic      ls_gate_off_o,
  output logic      hs_fully_on_o
);
  logic [3:0] hs_sh_r;
  logic [3:0] ls_sh_r;

  // Gate charge history; a slow stage needs four edges to settle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hs_sh_r <= 4'h0;
      ls_sh_r <= 4'h0;
    end else begin
      hs_sh_r <= {hs_sh_r[2:0], hs_gate_en_i};
      ls_sh_r <= {ls_sh_r[2:0], ls_gate_en_i};
    end
  end

  // Off flag drops at once on enable, returns only once the charge is gone
  assign hs_gate_off_o = !hs_gate_en_i && (slow_i ? (hs_sh_r == 4'h0) : !hs_sh_r[0]);
  assign ls_gate_off_o = !ls_gate_en_i && (slow_i ? (ls_sh_r == 4'h0) : !ls_sh_r[0]);
  assign hs_fully_on_o = hs_gate_en_i && (slow_i ? (&hs_sh_r) : hs_sh_r[0]);
endmodule

`default_nettype wire

// ==== half_bridge_control_logic_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module half_bridge_control_logic_bench;
  import hbc_pkg::*;
  localparam int unsigned OFFC = 8;
  logic clk_i = 1'b0, rstn_i = 1'b0;
  logic ser = 1'b0, ext = 1'b0, lok = 1'b1, slow = 1'b0, mok = 1'b1;
  logic sl = 1'b0, sl_d = 1'b1, off = 1'b1, off_d = 1'b1, cmd = 1'b0, cmd_d = 1'b1;
  logic r_off = 1'b0, r_cmd = 1'b0, off_sel = 1'b0, cmd_sel = 1'b0, key_wr = 1'b0;
  logic trip_en = 1'b0, trip = 1'b0, ssc = 1'b0;
  logic [2:0] slew_pin = 3'h0, r_slew = 3'h0, key = 3'h0;
  logic hs_en, ls_en, oe, outv, mir, diag, unl, fl, hs_off, ls_off, hs_on;
  logic [1:0] st;
  logic [2:0] slew_lv;
  logic signed [4:0] trim;
  int err_total = 0, checked = 0, seed, n, mx, mn;

  hbc_top #(.OFF_CYCLES(OFFC)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .serial_variant_i(ser), .ext_logic_supply_i(ext),
    .logic_supply_ok_i(lok), .motor_supply_ok_i(mok), .sleep_n_pin_i(sl),
    .sleep_n_pin_driven_i(sl_d), .drive_off_i(off), .drive_off_driven_i(off_d),
    .bridge_drive_cmd_i(cmd), .bridge_drive_cmd_driven_i(cmd_d), .slew_setting_i(slew_pin),
    .reg_drive_off_i(r_off), .reg_bridge_cmd_i(r_cmd), .drive_off_combine_sel_i(off_sel),
    .bridge_cmd_combine_sel_i(cmd_sel), .override_key_wr_i(key_wr),
    .override_lock_key_i(key), .reg_slew_setting_i(r_slew), .spread_spectrum_en_i(ssc),
    .trip_reg_en_i(trip_en), .trip_cmp_i(trip), .hs_gate_off_i(hs_off),
    .ls_gate_off_i(ls_off), .hs_fully_on_i(hs_on), .hs_gate_en_o(hs_en),
    .ls_gate_en_o(ls_en), .half_bridge_output_oe_o(oe), .half_bridge_output_o(outv),
    .current_mirror_en_o(mir), .offstate_diag_en_o(diag), .state_o(st),
    .override_unlocked_o(unl), .forced_low_o(fl), .slew_level_o(slew_lv),
    .osc_trim_o(trim));

  hbc_stage_model u_stage (.clk_i(clk_i), .rstn_i(rstn_i), .hs_gate_en_i(hs_en),
    .ls_gate_en_i(ls_en), .slow_i(slow), .hs_gate_off_o(hs_off), .ls_gate_off_o(ls_off),
    .hs_fully_on_o(hs_on));

  // Free running clock
  always #25 clk_i = ~clk_i;

  task automatic print_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic pins(input logic s, input logic o, input logic c);
    @(negedge clk_i);
    sl = s;
    off = o;
    cmd = c;
  endtask

  // Wait for the state, let gates and stage settle, then compare state and bridge outputs
  task automatic chk(input logic s, input logic o, input logic c);
    logic [1:0] e;
    e = !s ? 2'h0 : (o ? 2'h1 : 2'h2);
    n = 0;
    while (st !== e && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    // A slow stage needs about a dozen edges before the high side reads fully on
    cyc(14);
    cmp(8'(st), 8'(e), "state");
    cmp(8'(oe), 8'(e == 2'h2), "drive");
    cmp(8'(outv & oe), 8'(e == 2'h2 && c), "level");
    cmp(8'(ls_en), 8'(e == 2'h2 && !c), "low side");
    cmp(8'(mir), 8'(e == 2'h2 && c), "sense");
    cmp(8'(diag), 8'(e == 2'h1 && c), "diag");
    if (n == 20) begin
      err_total++;
      $display("FAIL %0t state wait timed out", $time);
      print_verdict();
    end
  endtask

  task automatic wait_fl(input logic v);
    n = 0;
    while (fl !== v && n < 6) begin
      @(negedge clk_i);
      n++;
    end
    cmp(8'(fl), 8'(v), "forced low");
    if (fl !== v)
      print_verdict();
  endtask

  task automatic kw(input logic [2:0] k);
    @(negedge clk_i);
    key_wr = 1'b1;
    key = k;
    @(negedge clk_i);
    key_wr = 1'b0;
  endtask

  // Shoot-through and sense current watched on every cycle
  always @(negedge clk_i) begin
    if (rstn_i) begin
      cmp(8'(hs_en & ls_en), 8'h0, "both gates");
      cmp(8'(mir), 8'(st == 2'h2 && outv && hs_on), "sense current");
    end
  end

  initial begin
    seed = 22012;
    cyc(4);
    rstn_i = 1'b1;
    // Full pin truth table
    for (int i = 0; i < 8; i++) begin
      pins(i[2], i[1], i[0]);
      chk(i[2], i[1], i[0]);
    end
    // Undriven pins fall back to their pull levels
    @(negedge clk_i);
    {sl_d, off_d, cmd_d} = 3'h0;
    pins(1'b1, 1'b0, 1'b1);
    chk(1'b0, 1'b1, 1'b0);
    sl_d = 1'b1;
    chk(1'b1, 1'b1, 1'b0);
    {off_d, cmd_d} = 2'h3;
    // No sleep pin: logic supply stands in for it
    ext = 1'b1;
    pins(1'b0, 1'b0, 1'b1);
    chk(1'b1, 1'b0, 1'b1);
    lok = 1'b0;
    chk(1'b0, 1'b0, 1'b1);
    {ext, lok} = 2'h1;
    // Pin slew latched at wake, clamped to six levels
    pins(1'b0, 1'b1, 1'b0);
    chk(1'b0, 1'b1, 1'b0);
    slew_pin = 3'h7;
    pins(1'b1, 1'b1, 1'b0);
    chk(1'b1, 1'b1, 1'b0);
    cmp(8'(slew_lv), 8'(SLEW_PIN_MAX), "slew clamp");
    slew_pin = 3'h2;
    cyc(6);
    cmp(8'(slew_lv), 8'(SLEW_PIN_MAX), "slew held");
    // Trip forces low for the full interval
    trip_en = 1'b1;
    pins(1'b1, 1'b0, 1'b1);
    chk(1'b1, 1'b0, 1'b1);
    trip = 1'b1;
    @(negedge clk_i);
    trip = 1'b0;
    wait_fl(1'b1);
    n = 0;
    while (fl === 1'b1 && n < 40) begin
      if (n == 4) begin
        cmp(8'(outv), 8'h0, "forced level");
        cmp(8'(ls_en), 8'h1, "forced low side");
      end
      n++;
      @(negedge clk_i);
    end
    cmp(8'(n), 8'(OFFC), "off interval");
    cyc(6);
    trip = 1'b1;
    @(negedge clk_i);
    trip = 1'b0;
    wait_fl(1'b1);
    pins(1'b1, 1'b0, 1'b0);
    wait_fl(1'b0);
    trip_en = 1'b0;
    // Serial variant: lock, then OR and AND combining
    ser = 1'b1;
    r_off = 1'b1;
    chk(1'b1, 1'b0, 1'b0);
    cmp(8'(unl), 8'h0, "locked");
    // A wrong second key drops the sequence back to locked
    kw(KEY_UNLOCK_A);
    kw(KEY_LOCK);
    kw(KEY_UNLOCK_B);
    cyc(1);
    cmp(8'(unl), 8'h0, "wrong key");
    kw(KEY_UNLOCK_A);
    kw(KEY_UNLOCK_B);
    cyc(1);
    cmp(8'(unl), 8'h1, "unlocked");
    chk(1'b1, 1'b1, 1'b0);
    off_sel = 1'b1;
    chk(1'b1, 1'b0, 1'b0);
    {r_off, off_sel, r_cmd} = 3'h1;
    chk(1'b1, 1'b0, 1'b1);
    cmd_sel = 1'b1;
    chk(1'b1, 1'b0, 1'b0);
    cmd_sel = 1'b0;
    pins(1'b0, 1'b0, 1'b0);
    chk(1'b0, 1'b0, 1'b1);
    // Sleep relocks, so wake and unlock again before testing the lock key
    pins(1'b1, 1'b0, 1'b0);
    chk(1'b1, 1'b0, 1'b0);
    cmp(8'(unl), 8'h0, "sleep relocks");
    kw(KEY_UNLOCK_A);
    kw(KEY_UNLOCK_B);
    chk(1'b1, 1'b0, 1'b1);
    kw(KEY_LOCK);
    chk(1'b1, 1'b0, 1'b0);
    cmp(8'(unl), 8'h0, "relocked");
    r_cmd = 1'b0;
    // Register slew follows every write
    repeat (12) begin
      @(negedge clk_i);
      r_slew = 3'($random(seed));
      cyc(2);
      cmp(8'(slew_lv), 8'(r_slew), "slew reg");
    end
    // Spread spectrum sweeps both extremes, then parks
    ssc = 1'b1;
    mx = -99;
    mn = 99;
    repeat (100) begin
      @(negedge clk_i);
      if (trim > mx)
        mx = trim;
      if (trim < mn)
        mn = trim;
    end
    cmp(8'(mx), 8'(SSC_SPREAD_PCT), "trim top");
    cmp(8'(mn), 8'(-SSC_SPREAD_PCT), "trim bottom");
    ssc = 1'b0;
    cyc(3);
    cmp(8'(trim), 8'h0, "trim off");
    // Random toggling against a stage of varying pace
    ser = 1'b0;
    pins(1'b1, 1'b0, 1'b0);
    repeat (300) begin
      @(negedge clk_i);
      cmd = 1'($random(seed));
      off = (3'($random(seed)) == 3'h0);
      slow = 1'($random(seed));
    end
    pins(1'b1, 1'b0, 1'b1);
    chk(1'b1, 1'b0, 1'b1);
    // Missing motor supply parks the bridge in standby
    mok = 1'b0;
    chk(1'b1, 1'b1, 1'b1);
    mok = 1'b1;
    chk(1'b1, 1'b0, 1'b1);
    print_verdict();
  end
endmodule

`default_nettype wire
